//--- rtl/pbmc_basic_mode_control.sv
// basic mode control register of a 10/100 Ethernet transceiver
//
// How it works
// - bit 15 starts reset, reads one meanwhile
// - reset end reloads strapped configuration values
// - bit 14 loops MII transmit to receive
// - loopback entry may hide receive data 500us
// - bit 13 picks speed; reset from strap
// - bit 12 enables negotiation, overriding speed, duplex
// - fiber mode strap clears negotiation enable at reset; a write can still set it
// - bit 11 powers down all but registers
// - power down is bit OR pin; pin sets bit
// - bit 10 isolates port from MII
// - bit 9 restarts negotiation, clears once started
// - restart ignored while negotiation disabled
// - clearing restart never aborts running negotiation
// - bit 8 picks duplex; reset from strap
// - collision test raises COL after TX_EN
// - collision test drops COL after TX_EN
`timescale 1ns/100ps
module pbmc_basic_mode_control
    import pbmc_pkg::*;
#(
    parameter int unsigned DEAD_CYCLES = DEAD_CYCLES_DEF
)
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire pbmc_mgmt_req_t mgmt_i,
    output logic [REG_W-1:0] rdata_o,
    input wire pbmc_strap_t strap_i,
    input wire logic power_down_request_pin_n_i,
    input wire logic an_started_i,
    input wire logic an_speed_100_i,
    input wire logic an_full_duplex_i,
    output logic an_restart_o,
    output logic aneg_en_o,
    output logic phy_reset_o,
    output logic power_down_o,
    output logic speed_100_o,
    output logic full_duplex_o,
    input wire pbmc_mii_tx_t mii_tx_i,
    input wire pbmc_mii_rx_t phy_rx_i,
    input wire logic phy_col_i,
    output pbmc_mii_rx_t mii_rx_o,
    output logic col_o,
    output logic mii_oe_o,
    output pbmc_mii_tx_t phy_tx_o
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    localparam int unsigned SYNC_W = 5;
    localparam logic [RST_CNT_W-1:0] SETTLE_LOAD =
        RST_CNT_W'(STRAP_SETTLE_CYCLES);
    localparam logic [RST_CNT_W-1:0] SOFT_LOAD =
        RST_CNT_W'(SOFT_RST_CYCLES);
    localparam logic [RST_CNT_W-1:0] CNT_LAST = 4'h1;

    function automatic logic addr_hit(input logic [4:0] addr);
        addr_hit = (addr == BMC_ADDR);
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // straps and the power down pin are asynchronous levels
    logic [SYNC_W-1:0] sync1_q, sync1_d;
    logic [SYNC_W-1:0] sync2_q, sync2_d;
    pbmc_strap_t strap_s;
    logic pdown_pin_n_s;

    always_comb
    begin
        sync1_d = {strap_i, power_down_request_pin_n_i};
        sync2_d = sync1_q;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            sync1_q <= 5'h01;
            sync2_q <= 5'h01;
        end
        else
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    assign strap_s = pbmc_strap_t'(sync2_q[SYNC_W-1:1]);
    assign pdown_pin_n_s = sync2_q[0];

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    pbmc_ctrl_t ctrl_q, ctrl_d;
    pbmc_ctrl_t wr_val;
    logic [RST_CNT_W-1:0] rst_cnt_q, rst_cnt_d;
    logic wr_hit;

    assign wr_val = pbmc_ctrl_t'(mgmt_i.wdata);
    assign wr_hit = mgmt_i.wr && addr_hit(mgmt_i.addr);

    always_comb
    begin
        ctrl_d = ctrl_q;
        rst_cnt_d = rst_cnt_q;
        if (rst_cnt_q != '0)
        begin
            // writes are ignored while a reset sequence runs
            rst_cnt_d = rst_cnt_q - 1'b1;
            if (rst_cnt_q == CNT_LAST)
            begin
                ctrl_d = BMC_RESET;
                ctrl_d.speed_100 = strap_s.speed_100;
                ctrl_d.full_duplex = strap_s.full_duplex;
                ctrl_d.aneg_en = strap_s.aneg_en
                                 && !strap_s.fiber_mode_enable;
            end
        end
        else
        begin
            // the engine acknowledges a pending restart
            if (ctrl_q.aneg_restart && an_started_i)
            begin
                ctrl_d.aneg_restart = 1'b0;
            end
            if (wr_hit)
            begin
                ctrl_d.loopback = wr_val.loopback;
                ctrl_d.speed_100 = wr_val.speed_100;
                ctrl_d.aneg_en = wr_val.aneg_en;
                ctrl_d.power_down = wr_val.power_down;
                ctrl_d.isolate = wr_val.isolate;
                ctrl_d.full_duplex = wr_val.full_duplex;
                ctrl_d.col_test = wr_val.col_test;
                // a written one wins over the acknowledge in this cycle;
                // a written zero only withdraws a request not yet taken
                ctrl_d.aneg_restart = wr_val.aneg_restart
                    || (ctrl_d.aneg_restart && wr_val.aneg_restart);
                if (wr_val.sw_reset)
                begin
                    ctrl_d.sw_reset = 1'b1;
                    rst_cnt_d = SOFT_LOAD;
                end
            end
        end
        if (!ctrl_d.aneg_en)
        begin
            ctrl_d.aneg_restart = 1'b0;
        end
        if (!pdown_pin_n_s)
        begin
            // pin sets the bit and beats any clearing write
            ctrl_d.power_down = 1'b1;
        end
        ctrl_d.rsvd = RSVD_VAL;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= BMC_RESET;
            rst_cnt_q <= SETTLE_LOAD;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            rst_cnt_q <= rst_cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    logic [REG_W-1:0] rdata_q, rdata_d;

    always_comb
    begin
        rdata_d = '0;
        if (mgmt_i.rd && addr_hit(mgmt_i.addr))
        begin
            rdata_d = ctrl_q;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

    // ------------------------------------------------------------------
    // effective mode outputs
    // ------------------------------------------------------------------
    logic pd_q, pd_d;
    logic spd_q, spd_d;
    logic dup_q, dup_d;

    always_comb
    begin
        pd_d = ctrl_q.power_down || !pdown_pin_n_s;
        if (ctrl_q.aneg_en)
        begin
            spd_d = an_speed_100_i;
            dup_d = an_full_duplex_i;
        end
        else
        begin
            spd_d = ctrl_q.speed_100;
            dup_d = ctrl_q.full_duplex;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            pd_q <= 1'b0;
            spd_q <= 1'b0;
            dup_q <= 1'b0;
        end
        else
        begin
            pd_q <= pd_d;
            spd_q <= spd_d;
            dup_q <= dup_d;
        end
    end

    assign power_down_o = pd_q;
    assign speed_100_o = spd_q;
    assign full_duplex_o = dup_q;
    assign aneg_en_o = ctrl_q.aneg_en;
    // level request held until the engine reports the restart
    assign an_restart_o = ctrl_q.aneg_restart;
    assign phy_reset_o = ctrl_q.sw_reset;

    // ------------------------------------------------------------------
    // MII path
    // ------------------------------------------------------------------
    pbmc_mii_path #(
        .DEAD_CYCLES(DEAD_CYCLES)
    ) u_mii_path (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .loopback_i(ctrl_q.loopback),
        .isolate_i(ctrl_q.isolate),
        .power_down_i(pd_q),
        .col_test_i(ctrl_q.col_test),
        .mii_tx_i(mii_tx_i),
        .phy_rx_i(phy_rx_i),
        .phy_col_i(phy_col_i),
        .mii_rx_o(mii_rx_o),
        .col_o(col_o),
        .mii_oe_o(mii_oe_o),
        .phy_tx_o(phy_tx_o)
    );

endmodule

//--- rtl/pbmc_pkg.sv
// package: layout, reset values and timing of the basic mode control block
package pbmc_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned CLK_FREQ_MHZ = 10;
    localparam int unsigned DEAD_TIME_US = 500;
    localparam int unsigned DEAD_CYCLES_DEF = DEAD_TIME_US * CLK_FREQ_MHZ;
    localparam int unsigned DEAD_CNT_W = 13;
    localparam int unsigned SOFT_RST_NS = 1000;
    localparam int unsigned SOFT_RST_CYCLES = SOFT_RST_NS / CLK_PERIOD_NS;
    localparam int unsigned STRAP_SETTLE_CYCLES = 3;
    localparam int unsigned RST_CNT_W = 4;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [4:0] BMC_ADDR = 5'h00;
    localparam int unsigned REG_W = 16;
    localparam int unsigned RSVD_W = 7;

    // field order gives bit 15 down to bit 0
    typedef struct packed {
        logic sw_reset;
        logic loopback;
        logic speed_100;
        logic aneg_en;
        logic power_down;
        logic isolate;
        logic aneg_restart;
        logic full_duplex;
        logic col_test;
        logic [RSVD_W-1:0] rsvd;
    } pbmc_ctrl_t;

    localparam pbmc_ctrl_t BMC_RESET = 16'h0000;
    localparam logic [RSVD_W-1:0] RSVD_VAL = 7'h00;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [REG_W-1:0] wdata;
    } pbmc_mgmt_req_t;

    typedef struct packed {
        logic speed_100;
        logic full_duplex;
        logic aneg_en;
        logic fiber_mode_enable;
    } pbmc_strap_t;

    typedef struct packed {
        logic tx_en;
        logic [3:0] txd;
    } pbmc_mii_tx_t;

    typedef struct packed {
        logic rx_dv;
        logic [3:0] rxd;
    } pbmc_mii_rx_t;

    localparam pbmc_mii_tx_t MII_TX_IDLE = 5'h00;
    localparam pbmc_mii_rx_t MII_RX_IDLE = 5'h00;

endpackage

//--- rtl/pbmc_mii_path.sv
// MII receive and transmit path: loopback, isolation, dead time and collision test
`timescale 1ns/100ps
module pbmc_mii_path
    import pbmc_pkg::*;
#(
    parameter int unsigned DEAD_CYCLES = DEAD_CYCLES_DEF
)
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic loopback_i,
    input wire logic isolate_i,
    input wire logic power_down_i,
    input wire logic col_test_i,
    input wire pbmc_mii_tx_t mii_tx_i,
    input wire pbmc_mii_rx_t phy_rx_i,
    input wire logic phy_col_i,
    output pbmc_mii_rx_t mii_rx_o,
    output logic col_o,
    output logic mii_oe_o,
    output pbmc_mii_tx_t phy_tx_o
);

    localparam logic [DEAD_CNT_W-1:0] DEAD_LOAD = DEAD_CNT_W'(DEAD_CYCLES);

    logic loop_q, loop_d;
    logic [DEAD_CNT_W-1:0] dead_q, dead_d;
    pbmc_mii_rx_t rx_q, rx_d;
    logic quiet;

    assign quiet = isolate_i | power_down_i;

    // ------------------------------------------------------------------
    // receive path
    // ------------------------------------------------------------------
    always_comb
    begin
        loop_d = loopback_i;
        dead_d = dead_q;
        rx_d = phy_rx_i;
        // descrambler resync hides valid data after loopback entry
        if (loopback_i && !loop_q)
        begin
            dead_d = DEAD_LOAD;
        end
        else if (dead_q != '0)
        begin
            dead_d = dead_q - 1'b1;
        end
        if (quiet)
        begin
            rx_d = MII_RX_IDLE;
        end
        else if (loopback_i)
        begin
            rx_d.rxd = mii_tx_i.txd;
            // the dead count loads one edge late, so the entry cycle
            // is masked by the loopback delay flop as well
            rx_d.rx_dv = mii_tx_i.tx_en && loop_q
                         && (dead_q == '0);
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            loop_q <= 1'b0;
            dead_q <= '0;
            rx_q <= MII_RX_IDLE;
        end
        else
        begin
            loop_q <= loop_d;
            dead_q <= dead_d;
            rx_q <= rx_d;
        end
    end

    assign mii_rx_o = rx_q;
    // combinational so that release follows transmit enable at once
    assign col_o = !quiet && ((col_test_i && mii_tx_i.tx_en)
                   || (!col_test_i && !loopback_i && phy_col_i));
    assign mii_oe_o = !quiet;
    // loopback keeps transmit data off the line
    assign phy_tx_o = (quiet || loopback_i) ? MII_TX_IDLE : mii_tx_i;

endmodule

//--- bench/pbmc_props.sv
// checker: timing relations at the ports of the control register block
`timescale 1ns/100ps
module pbmc_props
    import pbmc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire pbmc_mgmt_req_t mgmt_i,
    input wire logic power_down_request_pin_n_i,
    input wire logic an_started_i,
    input wire logic an_speed_100_i,
    input wire logic an_full_duplex_i,
    input wire logic an_restart_o,
    input wire logic aneg_en_o,
    input wire logic phy_reset_o,
    input wire logic power_down_o,
    input wire logic speed_100_o,
    input wire logic full_duplex_o,
    input wire pbmc_mii_tx_t mii_tx_i,
    input wire pbmc_mii_rx_t mii_rx_o,
    input wire logic col_o,
    input wire logic mii_oe_o,
    input wire pbmc_mii_tx_t phy_tx_o
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    logic w0;
    logic ct_q;
    logic ct_d;
    assign w0 = mgmt_i.wr && mgmt_i.addr == BMC_ADDR;
    // shadow of the collision test bit, cleared by a soft reset
    always_comb
    begin
        ct_d = ct_q;
        if (phy_reset_o)
            ct_d = 1'b0;
        else if (w0)
            ct_d = mgmt_i.wdata[7];
    end
    always_ff @(posedge sys_clk_i)
        ct_q <= rst_i ? 1'b0 : ct_d;
    AST_SOFT_RESET: assert property (
        w0 && mgmt_i.wdata[15] && !phy_reset_o |=>
        phy_reset_o [*8] ##[1:4] !phy_reset_o) else $error("soft reset");
    AST_PIN_PD: assert property (
        !power_down_request_pin_n_i [*5] |-> power_down_o)
        else $error("pin power down not seen");
    AST_RESTART_SET: assert property (
        w0 && mgmt_i.wdata[12] && mgmt_i.wdata[9] && !phy_reset_o
        |=> an_restart_o) else $error("restart not raised");
    AST_RESTART_CLR: assert property (
        an_restart_o && an_started_i && !(w0 && mgmt_i.wdata[9])
        |=> !an_restart_o) else $error("restart not cleared");
    AST_RESTART_OFF: assert property (
        w0 && !mgmt_i.wdata[12] && !phy_reset_o |=> !an_restart_o)
        else $error("restart taken while negotiation off");
    AST_ANEG_RESULT: assert property (
        $past(aneg_en_o) && !phy_reset_o |->
        speed_100_o == $past(an_speed_100_i) &&
        full_duplex_o == $past(an_full_duplex_i))
        else $error("negotiated mode not used");
    AST_PD_QUIET: assert property (
        power_down_o && $past(power_down_o) |->
        !mii_oe_o && phy_tx_o == MII_TX_IDLE) else $error("active in pd");
    AST_ISO_QUIET: assert property (
        !mii_oe_o && !$past(mii_oe_o) |->
        !col_o && mii_rx_o == MII_RX_IDLE) else $error("mii not quiet");
    AST_COL_RISE: assert property (
        ct_q && mii_oe_o && mii_tx_i.tx_en |-> col_o)
        else $error("collision test not echoed");
    AST_COL_FALL: assert property (
        ct_q && mii_oe_o && $fell(mii_tx_i.tx_en) |-> !col_o)
        else $error("collision test not dropped");
endmodule
bind pbmc_basic_mode_control pbmc_props u_props (.*);

//--- bench/pbmc_an_model.sv
// partner: negotiation engine answering restart requests
`timescale 1ns/100ps
module pbmc_an_model
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic restart_i,
    input wire logic slow_i,
    output logic started_o,
    output logic speed_100_o,
    output logic full_duplex_o
);
    logic [3:0] cnt_q;
    // a slow engine keeps the request pending so its read-back shows
    always @(posedge sys_clk_i)
    begin
        started_o <= 1'b0;
        if (rst_i)
        begin
            cnt_q <= 4'h0;
            {speed_100_o, full_duplex_o} <= 2'h0;
        end
        else if (restart_i && !started_o)
        begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q >= (slow_i ? 4'h9 : 4'h1))
            begin
                started_o <= 1'b1;
                cnt_q <= 4'h0;
                {speed_100_o, full_duplex_o} <= 2'($urandom);
            end
        end
    end
endmodule

//--- bench/pbmc_tb.sv
// testbench: control register block with a negotiation engine model
`timescale 1ns/100ps
module testbench import pbmc_pkg::*;;
    localparam int unsigned DEAD = 20;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    pbmc_mgmt_req_t mgmt_i = '0;
    pbmc_strap_t strap_i = '0;
    logic pd_n = 1'b1;
    logic slow = 1'b0;
    logic started, an_spd, an_fdx;
    pbmc_mii_tx_t mii_tx_i = '0;
    pbmc_mii_rx_t phy_rx_i = '0;
    logic phy_col_i = 1'b0;
    logic [15:0] rdata_o;
    logic an_restart_o, aneg_en_o, phy_reset_o, power_down_o;
    logic speed_100_o, full_duplex_o, col_o, mii_oe_o;
    pbmc_mii_rx_t mii_rx_o;
    pbmc_mii_tx_t phy_tx_o;
    logic [15:0] exp_q[$];
    logic take = 1'b0;
    int fails = 0, total_checks = 0, cycles = 0;

    always #50 sys_clk_i = ~sys_clk_i;

    pbmc_basic_mode_control #(.DEAD_CYCLES(DEAD)) uut (
        .sys_clk_i, .rst_i, .mgmt_i, .rdata_o, .strap_i,
        .power_down_request_pin_n_i(pd_n), .an_started_i(started),
        .an_speed_100_i(an_spd), .an_full_duplex_i(an_fdx),
        .an_restart_o, .aneg_en_o, .phy_reset_o, .power_down_o,
        .speed_100_o, .full_duplex_o, .mii_tx_i, .phy_rx_i, .phy_col_i,
        .mii_rx_o, .col_o, .mii_oe_o, .phy_tx_o);
    pbmc_an_model engine (.sys_clk_i, .rst_i, .restart_i(an_restart_o),
        .slow_i(slow), .started_o(started), .speed_100_o(an_spd),
        .full_duplex_o(an_fdx));

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, s);
        total_checks++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mgmt_i <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk_i);
        mgmt_i <= '0;
        @(posedge sys_clk_i);
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        mgmt_i <= '{1'b0, 1'b1, a, 16'h0000};
        exp_q.push_back(e);
        @(posedge sys_clk_i);
        mgmt_i <= '0;
        @(posedge sys_clk_i);
    endtask

    // read data stands for one cycle only, so it is taken right then
    always @(posedge sys_clk_i)
    begin
        if (take)
            chk("rdata", exp_q.pop_front(), rdata_o);
        take = mgmt_i.rd;
        cycles++;
        if (cycles > 3000)
        begin
            fails++;
            test_done();
        end
    end

    function automatic logic [15:0] sx(input pbmc_strap_t s);
        return {2'b00, s.speed_100, s.aneg_en & ~s.fiber_mode_enable,
            3'b000, s.full_duplex, 8'h00};
    endfunction

    task automatic hw_reset(input pbmc_strap_t s);
        rst_i <= 1'b1;
        strap_i <= s;
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
    endtask

    task automatic run(input int n, input int m);
        pbmc_mii_tx_t t, p;
        pbmc_mii_rx_t r, q;
        for (int i = 0; i < n; i++)
        begin
            p = t;
            q = r;
            t = 5'($urandom);
            r = 5'($urandom);
            mii_tx_i <= t;
            phy_rx_i <= r;
            phy_col_i <= (m == 0) && $urandom_range(1);
            @(negedge sys_clk_i);
            if (m == 1)
                chk("col", t.tx_en, col_o);
            if (m == 2 && i < DEAD - 5)
                chk("dead", 1'b0, mii_rx_o.rx_dv);
            if (m == 2 && i > DEAD + 5)
                chk("loop", p, mii_rx_o);
            if (m == 0 && i > 0)
                chk("rx", q, mii_rx_o);
            if (m == 0)
                chk("phycol", phy_col_i, col_o);
            if (m < 2)
                chk("tx", t, phy_tx_o);
            else
                chk("txidle", MII_TX_IDLE, phy_tx_o);
            if (m == 3)
                chk("oe", 1'b0, mii_oe_o);
            @(posedge sys_clk_i);
        end
    endtask

    initial
    begin
        pbmc_strap_t s;
        void'($urandom(32'hA58A0239));
        @(posedge sys_clk_i);
        for (int i = 0; i < 4; i++)
        begin
            s = 4'($urandom);
            s.fiber_mode_enable = i[0];
            s.aneg_en = i[1];
            hw_reset(s);
            rd(5'h00, sx(s));
        end
        $display("test straps done");
        wr(5'h00, 16'h25FF);
        rd(5'h00, 16'h2580);
        chk("mode", 2'b11, {speed_100_o, full_duplex_o});
        run(6, 3);
        wr(5'h01, 16'hFFFF);
        rd(5'h01, 16'h0000);
        wr(5'h00, 16'h0100);
        rd(5'h00, 16'h0100);
        chk("mode", 2'b01, {speed_100_o, full_duplex_o});
        $display("test fields done");
        slow <= 1'b1;
        wr(5'h00, 16'h1200);
        rd(5'h00, 16'h1200);
        for (int k = 0; k < 40 && an_restart_o; k++)
            @(posedge sys_clk_i);
        rd(5'h00, 16'h1000);
        chk("an", {an_spd, an_fdx}, {speed_100_o, full_duplex_o});
        wr(5'h00, 16'h0200);
        rd(5'h00, 16'h0000);
        $display("test negotiation done");
        wr(5'h00, 16'h0080);
        run(30, 1);
        wr(5'h00, 16'h0000);
        run(20, 0);
        wr(5'h00, 16'h4000);
        run(DEAD + 20, 2);
        $display("test mii done");
        pd_n <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        chk("pd", 2'b10, {power_down_o, mii_oe_o});
        wr(5'h00, 16'h0000);
        rd(5'h00, 16'h0800);
        pd_n <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        wr(5'h00, 16'h0000);
        rd(5'h00, 16'h0000);
        $display("test power down done");
        s = 4'($urandom);
        strap_i <= s;
        wr(5'h00, 16'h8000);
        rd(5'h00, 16'h8000);
        repeat (14) @(posedge sys_clk_i);
        rd(5'h00, sx(s));
        $display("test soft reset done");
        test_done();
    end
endmodule
